// File: verilog/valve_amp_enable_fault_control.sv
/*
  Enable, ready and fault supervision of a two-channel proportional valve amplifier, with an APB register slave
  through which the serial-link front end (or the commissioning tool) writes enables and setpoints.
  Assumes the hardware enable and the solenoid fault flags arrive asynchronously, the auxiliary converter
  samples arrive on pclk with a valid strobe, and the power stage consumes stage_cmd on pclk.
*/
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`include "valve_amp_defines.svh"

// Function
// RQ1: The power stage and ramp run only while hardware enable and the link enable bit are both set.
// RQ2: Fault-free operation is shown by a ready pin and a ready status bit sent over the link.
// RQ3: With fault monitoring on, a detected failure disables the power stage and drops ready.
// RQ4: With fault monitoring on, a failure stays latched until enable is dropped and raised again.
// RQ5: Directional mode takes one signed setpoint and shuts the whole unit down on any error.
// RQ6: Independent mode takes two unsigned setpoints, one for each channel.
// RQ7: Independent mode has a separate link enable bit for each channel.
// RQ8: In independent mode a solenoid fault disables only its channel and drops ready.
// RQ9: The two auxiliary analog samples are captured on their own and forwarded over the link.
// RQ10: In remote mode the physical enable and the bus commands are ignored in favour of the tool.
// RQ11: In remote mode a simulated hardware unlock stands in for the enable pin and is needed with channel enables.
// RQ12: Ready is on only when at least one channel is enabled and no error is present.
// RQ13: In directional mode a negative setpoint drives the second solenoid and a positive one the first.
// RQ14: The enable pin and the solenoid fault flags are synchronised before use.
module valve_amp_enable_fault_control (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic                         simulated_hw_unlock_pin,
  input  wire valve_amp_pkg::solenoid_fault_t solenoid_fault,
  input  wire valve_amp_pkg::aux_pair_t     aux_sample,
  input  wire logic                         aux_valid,
  output logic                              ready_pin,
  output valve_amp_pkg::stage_cmd_t         stage_cmd
);
  import valve_amp_pkg::*;

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  logic [2:0] sync_meta;
  logic [2:0] sync_q;
  logic [2:0] next_sync_meta;
  logic [2:0] next_sync_q;

  // RQ14 two-stage synchroniser.
  always_comb begin
    next_sync_meta = {simulated_hw_unlock_pin, solenoid_fault.fault_b, solenoid_fault.fault_a};
    next_sync_q    = sync_meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta <= 3'h0;
      sync_q    <= 3'h0;
    end else begin
      sync_meta <= next_sync_meta;
      sync_q    <= next_sync_q;
    end
  end

  logic pin_enable;
  logic flt_a;
  logic flt_b;
  assign flt_a      = sync_q[0];
  assign flt_b      = sync_q[1];
  assign pin_enable = sync_q[2];

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [2:0]     link_ctrl;
  logic [2:0]     config_reg;
  setpoint_pair_t link_sp;
  logic [2:0]     remote_ctrl;
  setpoint_pair_t remote_sp;
  aux_pair_t      aux_hold;
  logic [2:0]     next_link_ctrl;
  logic [2:0]     next_config_reg;
  setpoint_pair_t next_link_sp;
  logic [2:0]     next_remote_ctrl;
  setpoint_pair_t next_remote_sp;
  aux_pair_t      next_aux_hold;
  logic [31:0]    next_prdata;
  logic           next_pslverr;

  logic [5:0]     status_word;
  logic           wr_strobe;
  logic           rd_strobe;
  logic           addr_ok;

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == `OFF_LINK_CTRL) || (a == `OFF_CONFIG) || (a == `OFF_SETPOINT) ||
                  (a == `OFF_REMOTE_CTRL) || (a == `OFF_REMOTE_SP) || (a == `OFF_STATUS) ||
                  (a == `OFF_AUX) || (a == `OFF_OUTPUT);
  endfunction : addr_mapped

  assign pready    = 1'b1;
  assign addr_ok   = addr_mapped(paddr);
  assign wr_strobe = psel && penable && pwrite && addr_ok;
  assign rd_strobe = psel && !penable && !pwrite;

  logic remote_mode;
  assign remote_mode = config_reg[`BIT_REMOTE_MODE];

  always_comb begin
    next_link_ctrl   = link_ctrl;
    next_config_reg  = config_reg;
    next_link_sp     = link_sp;
    next_remote_ctrl = remote_ctrl;
    next_remote_sp   = remote_sp;
    next_aux_hold    = aux_hold;
    next_prdata      = prdata;
    next_pslverr     = 1'b0;
    // RQ9 aux sample capture.
    if (aux_valid) begin
      next_aux_hold = aux_sample;
    end
    if (wr_strobe) begin
      unique case (paddr)
        `OFF_CONFIG:      next_config_reg  = pwdata[2:0];
        `OFF_REMOTE_CTRL: next_remote_ctrl = pwdata[2:0];
        `OFF_REMOTE_SP:   next_remote_sp   = pwdata;
        // RQ10 bus commands ignored.
        `OFF_LINK_CTRL: begin
          if (!remote_mode) begin
            next_link_ctrl = pwdata[2:0];
          end
        end
        `OFF_SETPOINT: begin
          if (!remote_mode) begin
            next_link_sp = pwdata;
          end
        end
        default: begin
        end
      endcase
    end
    if (rd_strobe) begin
      next_pslverr = !addr_ok;
      unique case (paddr)
        `OFF_LINK_CTRL:   next_prdata = {29'h0, link_ctrl};
        `OFF_CONFIG:      next_prdata = {29'h0, config_reg};
        `OFF_SETPOINT:    next_prdata = link_sp;
        `OFF_REMOTE_CTRL: next_prdata = {29'h0, remote_ctrl};
        `OFF_REMOTE_SP:   next_prdata = remote_sp;
        `OFF_STATUS:      next_prdata = {26'h0, status_word};
        `OFF_AUX:         next_prdata = {4'h0, aux_hold.ch1, 4'h0, aux_hold.ch0};
        `OFF_OUTPUT:      next_prdata = {stage_cmd.drive_b, stage_cmd.drive_a};
        default:          next_prdata = 32'h0;
      endcase
    end else if (psel && !penable && !addr_ok) begin
      next_pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_ctrl   <= `RST_CTRL;
      config_reg  <= `RST_CONFIG;
      link_sp     <= `RST_SP;
      remote_ctrl <= `RST_CTRL;
      remote_sp   <= `RST_SP;
      aux_hold    <= '0;
      prdata      <= 32'h0;
      pslverr     <= 1'b0;
    end else begin
      link_ctrl   <= next_link_ctrl;
      config_reg  <= next_config_reg;
      link_sp     <= next_link_sp;
      remote_ctrl <= next_remote_ctrl;
      remote_sp   <= next_remote_sp;
      aux_hold    <= next_aux_hold;
      prdata      <= next_prdata;
      pslverr     <= next_pslverr;
    end
  end

  // Read data and the error flag are loaded at the end of the setup cycle, so that both stand
  // through the single access cycle in which pready is sampled high.

  // --------------------------------------------------------------------------
  // Enable selection
  // --------------------------------------------------------------------------
  logic           hw_en;
  logic           req_a;
  logic           req_b;
  logic           ind_mode;
  logic           mon_on;
  setpoint_pair_t sp;

  assign ind_mode = config_reg[`BIT_IND_MODE];
  assign mon_on   = config_reg[`BIT_MON_ON];

  always_comb begin
    // RQ11 simulated unlock.
    if (remote_mode) begin
      hw_en = remote_ctrl[`BIT_HW_UNLOCK];
      req_a = remote_ctrl[`BIT_EN_A];
      req_b = remote_ctrl[`BIT_EN_B];
      sp    = remote_sp;
    end else begin
      hw_en = pin_enable;
      req_a = link_ctrl[`BIT_EN_A];
      req_b = link_ctrl[`BIT_EN_B];
      sp    = link_sp;
    end
  end

  logic en_a;
  logic en_b;
  // RQ1 hardware and link AND.
  assign en_a = hw_en && req_a;
  // RQ7 per-channel enable.
  assign en_b = hw_en && (ind_mode ? req_b : req_a);

  // --------------------------------------------------------------------------
  // Fault latches
  // --------------------------------------------------------------------------
  logic err_a;
  logic err_b;
  logic next_err_a;
  logic next_err_b;

  always_comb begin
    next_err_a = err_a;
    next_err_b = err_b;
    // RQ4 cleared by enable drop.
    if (!en_a) begin
      next_err_a = 1'b0;
    end
    if (!en_b) begin
      next_err_b = 1'b0;
    end
    // RQ3 latch while monitoring; the set wins over the clear.
    if (mon_on && flt_a) begin
      next_err_a = 1'b1;
    end
    if (mon_on && flt_b) begin
      next_err_b = 1'b1;
    end
    if (!mon_on) begin
      next_err_a = 1'b0;
      next_err_b = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_a <= 1'b0;
      err_b <= 1'b0;
    end else begin
      err_a <= next_err_a;
      err_b <= next_err_b;
    end
  end

  // --------------------------------------------------------------------------
  // Power stage command and ready
  // --------------------------------------------------------------------------
  logic       any_err;
  logic       run_a;
  logic       run_b;
  stage_cmd_t next_stage_cmd;
  logic       next_ready_pin;
  logic       sp_neg;
  logic [`SP_W-1:0] sp_mag;

  assign any_err = err_a || err_b;
  assign sp_neg  = sp.a[`SP_W-1];
  assign sp_mag  = sp_neg ? `SP_W'(~sp.a + 1'b1) : sp.a;

  always_comb begin
    if (ind_mode) begin
      // RQ8 only faulty channel off.
      run_a = en_a && !err_a;
      run_b = en_b && !err_b;
    end else begin
      // RQ5 whole unit off.
      run_a = en_a && !any_err;
      run_b = run_a;
    end
    next_stage_cmd = '0;
    next_stage_cmd.ramp_run = run_a || run_b;
    if (ind_mode) begin
      // RQ6 two unsigned setpoints.
      next_stage_cmd.stage_a = run_a;
      next_stage_cmd.stage_b = run_b;
      next_stage_cmd.drive_a = run_a ? sp.a : '0;
      next_stage_cmd.drive_b = run_b ? sp.b : '0;
    end else begin
      // RQ13 sign steers solenoid.
      next_stage_cmd.stage_a = run_a && !sp_neg;
      next_stage_cmd.stage_b = run_a && sp_neg;
      next_stage_cmd.drive_a = (run_a && !sp_neg) ? sp_mag : '0;
      next_stage_cmd.drive_b = (run_a && sp_neg) ? sp_mag : '0;
    end
    // RQ12 ready condition.
    next_ready_pin = (en_a || (ind_mode && en_b)) && !any_err;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_cmd <= '0;
      ready_pin <= 1'b0;
    end else begin
      stage_cmd <= next_stage_cmd;
      ready_pin <= next_ready_pin;
    end
  end

  // RQ2 ready on link status.
  assign status_word = {hw_en, stage_cmd.stage_b, stage_cmd.stage_a, err_b, err_a, ready_pin};

endmodule : valve_amp_enable_fault_control

// File: verilog/valve_amp_defines.svh
/*
  Offsets, field positions, reset values and widths of the valve amplifier enable and fault supervision block.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef VALVE_AMP_DEFINES_SVH
`define VALVE_AMP_DEFINES_SVH

`define SP_W             16
`define AUX_W            12

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFF_LINK_CTRL    12'h000
`define OFF_CONFIG       12'h004
`define OFF_SETPOINT     12'h008
`define OFF_REMOTE_CTRL  12'h00C
`define OFF_REMOTE_SP    12'h010
`define OFF_STATUS       12'h014
`define OFF_AUX          12'h018
`define OFF_OUTPUT       12'h01C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_EN_A         0
`define BIT_EN_B         1
`define BIT_HW_UNLOCK    2
`define BIT_MON_ON       0
`define BIT_IND_MODE     1
`define BIT_REMOTE_MODE  2
`define BIT_READY        0
`define BIT_ERR_A        1
`define BIT_ERR_B        2
`define BIT_STAGE_A      3
`define BIT_STAGE_B      4
`define BIT_HW_EN        5

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_CTRL         3'h0
`define RST_CONFIG       3'h1
`define RST_SP           32'h00000000

`endif

// File: verilog/valve_amp_pkg.sv
/*
  Types shared by the valve amplifier enable and fault supervision block.
  Assumes the defines header is on the include path.
*/
`include "valve_amp_defines.svh"

package valve_amp_pkg;

  typedef struct packed {
    logic [`SP_W-1:0] a;
    logic [`SP_W-1:0] b;
  } setpoint_pair_t;

  typedef struct packed {
    logic fault_a;
    logic fault_b;
  } solenoid_fault_t;

  typedef struct packed {
    logic             stage_a;
    logic             stage_b;
    logic             ramp_run;
    logic [`SP_W-1:0] drive_a;
    logic [`SP_W-1:0] drive_b;
  } stage_cmd_t;

  typedef struct packed {
    logic [`AUX_W-1:0] ch0;
    logic [`AUX_W-1:0] ch1;
  } aux_pair_t;

endpackage : valve_amp_pkg

// File: verif/valve_amp_checker_properties.sv
/* Checker for the valve amplifier enable and fault block.
   Assumes it is bound to the design top and sees only its ports. */
`timescale 1ns/1ns
module valve_amp_checker import valve_amp_pkg::*; (
  input wire logic                            pclk,
  input wire logic                            presetn,
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [11:0]                     paddr,
  input wire logic [31:0]                     pwdata,
  input wire logic [31:0]                     prdata,
  input wire logic                            pready,
  input wire logic                            pslverr,
  input wire logic                            simulated_hw_unlock_pin,
  input wire valve_amp_pkg::solenoid_fault_t  solenoid_fault,
  input wire valve_amp_pkg::aux_pair_t        aux_sample,
  input wire logic                            aux_valid,
  input wire logic                            ready_pin,
  input wire valve_amp_pkg::stage_cmd_t       stage_cmd
);
  logic mon;
  logic independent_mode;
  logic remote;
  // Shadow of the mode register, taken from completed bus writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {remote, independent_mode, mon} <= 3'h1;
    else if (psel && penable && pwrite && paddr == 12'h004) {remote, independent_mode, mon} <= pwdata[2:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_high: assert property (pready)
    else $error("pready low");
  a_stage_needs_pin: assert property (!remote && stage_cmd.stage_a |->
    $past(simulated_hw_unlock_pin, 3) || $past(simulated_hw_unlock_pin, 4)) else $error("stage on without enable pin");
  a_ramp_with_stage: assert property (stage_cmd.ramp_run |-> stage_cmd.stage_a || stage_cmd.stage_b)
    else $error("ramp runs with stage off");
  a_fault_drops_ready: assert property (mon && $past(solenoid_fault, 5) != 2'h0 |-> !ready_pin)
    else $error("ready on after fault");
  a_fault_a_kills: assert property (mon && $past(solenoid_fault.fault_a, 5) |-> !stage_cmd.stage_a)
    else $error("channel A on after fault");
  a_fault_b_kills: assert property (mon && $past(solenoid_fault.fault_b, 5) |-> !stage_cmd.stage_b)
    else $error("channel B on after fault");
  a_dir_whole_off: assert property (mon && !independent_mode && $past(solenoid_fault.fault_b, 5) |-> !stage_cmd.stage_a)
    else $error("unit on after fault");
  a_dir_one_side: assert property (!independent_mode && !$past(independent_mode) && !$past(independent_mode, 2) |->
    stage_cmd.drive_a == 16'h0000 || stage_cmd.drive_b == 16'h0000) else $error("both sides driven");
  a_err_after_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr without access");
  a_unmapped_err: assert property (psel && penable && paddr >= 12'h020 |-> pslverr)
    else $error("no pslverr on unmapped access");
  a_ready_needs_pin: assert property (!remote && !$past(remote) && ready_pin |-> $past(simulated_hw_unlock_pin, 3))
    else $error("ready on without enable pin");
endmodule : valve_amp_checker

bind valve_amp_enable_fault_control valve_amp_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .simulated_hw_unlock_pin(simulated_hw_unlock_pin), .solenoid_fault(solenoid_fault),
  .aux_sample(aux_sample), .aux_valid(aux_valid), .ready_pin(ready_pin), .stage_cmd(stage_cmd));

// File: verif/link_master_model.sv
/* Link master model: issues APB transfers on behalf of the PLC side.
   Assumes pready, prdata and pslverr come from the block and stand during the access cycle. */
`timescale 1ns/1ns
module link_master_model (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  logic last_err;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = 47'h0;
    last_err = 1'b0;
  end
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    {psel, penable} <= 2'h0;
  endtask : xfer
endmodule : link_master_model

// File: verif/testbench.sv
/* Self-checking bench of the valve amplifier enable and fault block.
   Assumes the link master model and the bound checker are compiled alongside. */
`timescale 1ns/1ns
`include "valve_amp_defines.svh"
module testbench;
  import valve_amp_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, simulated_hw_unlock_pin = 1'b0;
  logic aux_valid = 1'b0, ready_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  solenoid_fault_t solenoid_fault = 2'h0;
  aux_pair_t aux_sample = 24'h0;
  stage_cmd_t stage_cmd;
  int errors = 0, total_checks = 0, cycles = 0;
  valve_amp_enable_fault_control u_valve_amp_enable_fault_control (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .simulated_hw_unlock_pin(simulated_hw_unlock_pin), .solenoid_fault(solenoid_fault),
    .aux_sample(aux_sample), .aux_valid(aux_valid), .ready_pin(ready_pin), .stage_cmd(stage_cmd));
  link_master_model u_link (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_link.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    u_link.xfer(1'b0, a, 32'h0, q);
  endtask : rd
  // Pin and fault levels, then the sync plus register latency with margin.
  task automatic pins(input logic pin, input logic [1:0] f);
    @(posedge pclk);
    simulated_hw_unlock_pin <= pin;
    solenoid_fault <= f;
    repeat (6) @(posedge pclk);
  endtask : pins
  task automatic out(input logic [2:0] e);
    chk({29'h0, stage_cmd.stage_a, stage_cmd.stage_b, ready_pin}, {29'h0, e});
  endtask : out
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_dir;
    out(3'b000);
    rd(`OFF_CONFIG); chk(q, 32'h1);
    chk(u_link.last_err, 1'b0);
    rd(12'h040); chk(q, 32'h0);
    chk(u_link.last_err, 1'b1);
    wr(`OFF_SETPOINT, 32'h12340000); wr(`OFF_LINK_CTRL, 32'h1);
    pins(1'b0, 2'h0); chk(stage_cmd.stage_a, 1'b0);
    pins(1'b1, 2'h0); out(3'b101); chk(stage_cmd.drive_a, 16'h1234);
    chk(stage_cmd.ramp_run, 1'b1);
    rd(`OFF_STATUS); chk(q[0], 1'b1);
    wr(`OFF_SETPOINT, 32'hFF000000); pins(1'b1, 2'h0); chk(stage_cmd[31:0], 32'h00000100);
    pins(1'b1, 2'h1); out(3'b000);
    chk(stage_cmd.ramp_run, 1'b0);
    pins(1'b1, 2'h2); out(3'b000);
    pins(1'b1, 2'h0); out(3'b000);
    wr(`OFF_LINK_CTRL, 32'h0); pins(1'b1, 2'h0); wr(`OFF_LINK_CTRL, 32'h1); pins(1'b1, 2'h0);
    out(3'b011);
    $display("test directional done");
  endtask : t_dir
  task automatic t_ind;
    wr(`OFF_LINK_CTRL, 32'h0); wr(`OFF_CONFIG, 32'h3); wr(`OFF_SETPOINT, 32'h01000200);
    wr(`OFF_LINK_CTRL, 32'h2); pins(1'b1, 2'h0); out(3'b011); chk(stage_cmd.drive_b, 16'h0200);
    wr(`OFF_LINK_CTRL, 32'h3); pins(1'b1, 2'h0); chk(stage_cmd[31:0], 32'h01000200);
    pins(1'b1, 2'h2); out(3'b010);
    wr(`OFF_LINK_CTRL, 32'h1); pins(1'b1, 2'h0); wr(`OFF_CONFIG, 32'h1);
    $display("test independent done");
  endtask : t_ind
  task automatic t_remote;
    pins(1'b0, 2'h0); wr(`OFF_CONFIG, 32'h5); wr(`OFF_REMOTE_SP, 32'h00500000);
    wr(`OFF_REMOTE_CTRL, 32'h1); pins(1'b0, 2'h0); chk(stage_cmd.stage_a, 1'b0);
    wr(`OFF_REMOTE_CTRL, 32'h5); pins(1'b0, 2'h0); chk(stage_cmd.stage_a, 1'b1);
    chk(stage_cmd.drive_a, 16'h0050);
    wr(`OFF_LINK_CTRL, 32'h0); rd(`OFF_LINK_CTRL); chk(q, 32'h1);
    wr(`OFF_SETPOINT, 32'h7FFF0000);
    rd(`OFF_SETPOINT);
    chk(q, 32'h01000200);
    wr(`OFF_REMOTE_CTRL, 32'h0); pins(1'b0, 2'h0); wr(`OFF_CONFIG, 32'h1);
    $display("test remote done");
  endtask : t_remote
  task automatic t_aux;
    @(posedge pclk);
    aux_sample <= 24'hABC123;
    aux_valid <= 1'b1;
    @(posedge pclk);
    aux_valid <= 1'b0;
    rd(`OFF_AUX); chk(q, 32'h01230ABC);
    $display("test aux done");
  endtask : t_aux
  // With monitoring off a solenoid fault neither latches nor stops the stage.
  task automatic t_nomon;
    wr(`OFF_CONFIG, 32'h0);
    pins(1'b1, 2'h2);
    out(3'b101);
    pins(1'b1, 2'h0);
    out(3'b101);
    wr(`OFF_CONFIG, 32'h1);
    $display("test monitoring off done");
  endtask : t_nomon
  // Reset in mid-run while the stage is on, then the reset values again.
  task automatic t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    out(3'b000);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    out(3'b000);
    rd(`OFF_LINK_CTRL);
    chk(q, 32'h0);
    rd(`OFF_CONFIG);
    chk(q, 32'h1);
    $display("test reset done");
  endtask : t_reset
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_dir();
    t_ind();
    t_remote();
    t_aux();
    t_nomon();
    t_reset();
    report_and_stop();
  end
endmodule : testbench
